// File: ucie_pkg.sv
// Package: register map, field positions, reset values and timing counts for the USB event block
package ucie_pkg;
    // ****************************************
    // Register indices (printed offsets are not all multiples of four)
    // ****************************************
    localparam logic [7:0] UCIE_IDX_CMN_FLAGS = 8'h06;
    localparam logic [7:0] UCIE_IDX_IN_EN     = 8'h07;
    localparam logic [7:0] UCIE_IDX_IN_FLAGS  = 8'h02;
    localparam logic [7:0] UCIE_IDX_CTRL      = 8'h10;
    localparam logic [7:0] UCIE_IDX_IRQ_STAT  = 8'h11;
    localparam logic [7:0] UCIE_IDX_IRQ_MASK  = 8'h12;
    localparam logic [7:0] UCIE_IDX_STATE     = 8'h13;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int UCIE_BIT_SUSP  = 0;
    localparam int UCIE_BIT_RESUM = 1;
    localparam int UCIE_BIT_BRST  = 2;
    localparam int UCIE_BIT_SOF   = 3;
    localparam int UCIE_BIT_EP0   = 0;
    localparam int UCIE_BIT_CTRL_SUSPEND_DETECT_ENABLE = 0;
    localparam logic [3:0] UCIE_RST_CMN_FLAGS = 4'h0;
    localparam logic [3:0] UCIE_RST_IN_EN     = 4'hF;
    localparam logic [3:0] UCIE_RST_IN_FLAGS  = 4'h0;
    localparam logic [0:0] UCIE_RST_CTRL      = 1'h0;
    localparam logic [1:0] UCIE_RST_IRQ_MASK  = 2'h3;

    // ****************************************
    // Timing: frame period 1 ms, plus slack before synthesizing a missed SOF
    // ****************************************
    localparam int UCIE_CLK_MHZ       = 125;
    localparam int UCIE_FRAME_US      = 1000;
    localparam int UCIE_FRAME_CYC     = UCIE_FRAME_US * UCIE_CLK_MHZ;
    localparam int UCIE_SOF_SLACK_CYC = 125;
    localparam int UCIE_TMR_W         = 18;

    function automatic logic [31:0] ucie_byte_addr(input logic [7:0] idx);
        return {22'h0, idx, 2'h0};
    endfunction
endpackage

// File: ucie_flag_if.sv
// Interface: a four-bit sticky flag group with set, read-clear and current value
`timescale 1ns/1ps
interface ucie_flag_if;
    logic [3:0] set_req;
    logic       rd_clr;
    logic [3:0] flags;
    modport owner (input set_req, input rd_clr, output flags);
    modport user  (output set_req, output rd_clr, input flags);
endinterface

// File: ucie_flag_reg.sv
// Module: four sticky flags, set wins over a clearing read
`timescale 1ns/1ps
module ucie_flag_reg
    import ucie_pkg::*;
#(
    parameter logic [3:0] RST_VAL = 4'h0
) (
    input  wire logic   pclk,
    input  wire logic   presetn,
    ucie_flag_if.owner  fl
);
    logic [3:0] flags_ff;
    logic [3:0] nxt_flags;

    // A set landing on the clearing read stays pending
    assign nxt_flags = (fl.rd_clr ? 4'h0 : flags_ff) | fl.set_req;
    assign fl.flags  = flags_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= RST_VAL;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
        |fl.set_req |=> ((flags_ff & $past(fl.set_req)) == $past(fl.set_req)))
        else $error("flag set was lost");
endmodule

// File: ucie_top.sv
// Module: USB common event flags and IN endpoint interrupt enables behind APB
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module ucie_top
    import ucie_pkg::*;
#(
    parameter int FRAME_CYC = UCIE_FRAME_CYC,
    parameter int SLACK_CYC = UCIE_SOF_SLACK_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sof_token,
    input  wire logic        bus_reset_seen,
    input  wire logic        resume_seen,
    input  wire logic        suspend_seen,
    input  wire logic [3:0]  in_ep_event,
    output logic             usb_irq,
    output logic             irq
);
    // ****************************************
    // Pin synchronisers for bus-line events
    // ****************************************
    logic [3:0] pin_s1_ff;
    logic [3:0] pin_s2_ff;
    logic [3:0] pin_d_ff;
    logic [3:0] pin_rise;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_ff <= 4'h0;
            pin_s2_ff <= 4'h0;
            pin_d_ff  <= 4'h0;
        end else begin
            pin_s1_ff <= {sof_token, bus_reset_seen, resume_seen, suspend_seen};
            pin_s2_ff <= pin_s1_ff;
            pin_d_ff  <= pin_s2_ff;
        end
    end
    assign pin_rise = pin_s2_ff & ~pin_d_ff;

    // ****************************************
    // APB decode
    // ****************************************
    logic acc;
    logic wr;
    logic rd;
    logic hit_cmn;
    logic hit_en;
    logic hit_inf;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_mask;
    logic hit_state;
    logic hit_any;

    assign acc       = psel & penable;
    assign wr        = acc & pwrite;
    assign rd        = acc & ~pwrite;
    assign hit_cmn   = paddr == ucie_byte_addr(UCIE_IDX_CMN_FLAGS);
    assign hit_en    = paddr == ucie_byte_addr(UCIE_IDX_IN_EN);
    assign hit_inf   = paddr == ucie_byte_addr(UCIE_IDX_IN_FLAGS);
    assign hit_ctrl  = paddr == ucie_byte_addr(UCIE_IDX_CTRL);
    assign hit_stat  = paddr == ucie_byte_addr(UCIE_IDX_IRQ_STAT);
    assign hit_mask  = paddr == ucie_byte_addr(UCIE_IDX_IRQ_MASK);
    assign hit_state = paddr == ucie_byte_addr(UCIE_IDX_STATE);
    assign hit_any   = hit_cmn | hit_en | hit_inf | hit_ctrl | hit_stat | hit_mask | hit_state;
    // Zero-wait slave: every access completes in its first access cycle
    assign pready    = 1'b1;
    assign pslverr   = acc & ~hit_any;

    // ****************************************
    // Software-written registers
    // ****************************************
    logic [3:0] in_en_ff;
    logic [0:0] ctrl_ff;
    logic [1:0] irq_mask_ff;
    logic       susp_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_en_ff    <= UCIE_RST_IN_EN;
            ctrl_ff     <= UCIE_RST_CTRL;
            irq_mask_ff <= UCIE_RST_IRQ_MASK;
        end else begin
            if (wr && hit_en) begin
                in_en_ff <= pwdata[3:0];
            end
            if (wr && hit_ctrl) begin
                ctrl_ff <= pwdata[0:0];
            end
            if (wr && hit_mask) begin
                irq_mask_ff <= pwdata[1:0];
            end
        end
    end

    // ****************************************
    // Frame timer: synthesizes SOF when a token is missed
    // ****************************************
    logic [UCIE_TMR_W-1:0] frm_ff;
    logic [UCIE_TMR_W-1:0] nxt_frm;
    logic                  frm_run_ff;
    logic                  sof_synth;
    logic                  sof_evt;

    // SOF is only synthesized after a real SOF has locked frame timing; the counter runs except while suspended, and a bus reset clears it
    assign sof_synth = frm_run_ff && (frm_ff == UCIE_TMR_W'(FRAME_CYC + SLACK_CYC - 1));
    assign sof_evt   = pin_rise[UCIE_BIT_SOF] | sof_synth;
    assign nxt_frm   = sof_evt ? UCIE_TMR_W'(SLACK_CYC) : frm_ff + UCIE_TMR_W'(1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frm_ff     <= '0;
            frm_run_ff <= 1'b0;
        end else begin
            frm_ff <= (susp_ff || pin_rise[UCIE_BIT_BRST]) ? '0 : nxt_frm;
            if (pin_rise[UCIE_BIT_SOF]) begin
                frm_run_ff <= 1'b1;
            end else if (susp_ff || pin_rise[UCIE_BIT_BRST]) begin
                frm_run_ff <= 1'b0;
            end
        end
    end

    // ****************************************
    // Suspend state of the core
    // ****************************************
    logic susp_evt;
    logic resum_evt;

    assign susp_evt  = ctrl_ff[UCIE_BIT_CTRL_SUSPEND_DETECT_ENABLE] & pin_rise[UCIE_BIT_SUSP];
    assign resum_evt = susp_ff & pin_rise[UCIE_BIT_RESUM];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            susp_ff <= 1'b0;
        end else if (susp_evt) begin
            susp_ff <= 1'b1;
        end else if (resum_evt || pin_rise[UCIE_BIT_BRST]) begin
            susp_ff <= 1'b0;
        end
    end

    // ****************************************
    // Flag registers
    // ****************************************
    ucie_flag_if cmn_if ();
    ucie_flag_if inf_if ();

    assign cmn_if.set_req[UCIE_BIT_SOF]   = sof_evt;
    assign cmn_if.set_req[UCIE_BIT_BRST]  = pin_rise[UCIE_BIT_BRST];
    assign cmn_if.set_req[UCIE_BIT_RESUM] = resum_evt;
    assign cmn_if.set_req[UCIE_BIT_SUSP]  = susp_evt;
    assign cmn_if.rd_clr                  = rd & hit_cmn;
    // Endpoint events come from core logic on this clock: no synchroniser
    assign inf_if.set_req                 = in_ep_event;
    assign inf_if.rd_clr                  = rd & hit_inf;

    ucie_flag_reg #(.RST_VAL(UCIE_RST_CMN_FLAGS)) u_cmn (
        .pclk    (pclk),
        .presetn (presetn),
        .fl      (cmn_if.owner)
    );

    ucie_flag_reg #(.RST_VAL(UCIE_RST_IN_FLAGS)) u_inf (
        .pclk    (pclk),
        .presetn (presetn),
        .fl      (inf_if.owner)
    );

    // ****************************************
    // Interrupts
    // ****************************************
    logic [1:0] irq_stat_ff;
    logic [1:0] irq_evt;
    logic       usb_irq_ff;
    logic       ep_pend;

    assign ep_pend = |(inf_if.flags & in_en_ff);
    assign irq_evt = {|cmn_if.set_req, |(inf_if.set_req & in_en_ff)};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= 2'h0;
            usb_irq_ff  <= 1'b0;
        end else begin
            irq_stat_ff <= ((rd && hit_stat) ? 2'h0 : irq_stat_ff) | irq_evt;
            usb_irq_ff  <= ep_pend;
        end
    end
    assign usb_irq = usb_irq_ff;
    assign irq     = |(irq_stat_ff & irq_mask_ff);

    // ****************************************
    // Read data, registered at the edge that ends the setup phase
    // ****************************************
    logic [31:0] rmux;
    logic [31:0] prdata_ff;

    // Upper bits of every register read as zero
    assign rmux = hit_cmn   ? {28'h0, cmn_if.flags} :
                  hit_en    ? {28'h0, in_en_ff} :
                  hit_inf   ? {28'h0, inf_if.flags} :
                  hit_ctrl  ? {31'h0, ctrl_ff} :
                  hit_stat  ? {30'h0, irq_stat_ff} :
                  hit_mask  ? {30'h0, irq_mask_ff} :
                  hit_state ? {30'h0, frm_run_ff, susp_ff} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= rmux;
        end
    end
    assign prdata = prdata_ff;

    // ****************************************
    // Checks
    // ****************************************
    AST_SOF_SET: assert property (@(posedge pclk) disable iff (!presetn)
        pin_rise[UCIE_BIT_SOF] |=> cmn_if.flags[UCIE_BIT_SOF])
        else $error("SOF token did not set flag");
    AST_SOF_SYNTH: assert property (@(posedge pclk) disable iff (!presetn)
        sof_synth |=> cmn_if.flags[UCIE_BIT_SOF])
        else $error("synthesized SOF did not set flag");
    AST_RD_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        (rd && hit_cmn && !(|cmn_if.set_req)) |=> cmn_if.flags == 4'h0)
        else $error("read did not clear common flags");
    AST_RESET_SET: assert property (@(posedge pclk) disable iff (!presetn)
        pin_rise[UCIE_BIT_BRST] |=> cmn_if.flags[UCIE_BIT_BRST])
        else $error("bus reset flag not set");
    AST_RESUME_ONLY_SUSP: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cmn_if.flags[UCIE_BIT_RESUM]) |-> $past(susp_ff))
        else $error("resume flag set while not suspended");
    AST_EP0_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        (inf_if.flags == 4'h1 && !in_en_ff[UCIE_BIT_EP0]) |=> !usb_irq)
        else $error("disabled control endpoint raised irq");
    AST_EP_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        |(inf_if.flags & in_en_ff) |=> usb_irq)
        else $error("enabled endpoint flag did not raise irq");
    AST_EP_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        !(|(inf_if.flags & in_en_ff)) |=> !usb_irq)
        else $error("irq raised with no enabled flag");
    AST_EN_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit_en) |=> in_en_ff == $past(pwdata[3:0]))
        else $error("enable register did not take write");
    AST_IN_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        (rd && hit_inf && in_ep_event == 4'h0) |=> inf_if.flags == 4'h0)
        else $error("endpoint flags not cleared by read");
    AST_SUSP_EN: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cmn_if.flags[UCIE_BIT_SUSP]) |-> $past(ctrl_ff[UCIE_BIT_CTRL_SUSPEND_DETECT_ENABLE]))
        else $error("suspend flag set while detection disabled");
    AST_UPPER_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && (hit_cmn || hit_en)) |=> prdata[31:4] == 28'h0)
        else $error("upper bits not zero");
endmodule

// File: ucie_host_model.sv
// Host-side model: stretches event requests into bus condition levels
`timescale 1ns/1ps
module ucie_host_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] kick,
    input  wire logic [3:0] ep_kick,
    output logic      [3:0] line_lvl,
    output logic      [3:0] in_ep_event
);
    logic [3:0] a_ff;
    logic [3:0] b_ff;
    logic [3:0] c_ff;

    // ****************************************
    // Line levels
    // ****************************************
    // Three cycles high so the two-stage synchroniser cannot miss an event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_ff        <= 4'h0;
            b_ff        <= 4'h0;
            c_ff        <= 4'h0;
            in_ep_event <= 4'h0;
        end else begin
            a_ff        <= kick;
            b_ff        <= a_ff;
            c_ff        <= b_ff;
            in_ep_event <= ep_kick;
        end
    end
    assign line_lvl = a_ff | b_ff | c_ff;
endmodule

// File: tb_ucie_top.sv
// Testbench: event flags, endpoint enables and interrupts over APB
`timescale 1ns/1ps
module tb_ucie_top;
    import ucie_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, usb_irq, irq, serr;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [3:0]  kick, ep_kick, lvl, in_ep_event, en, ev;
    int          seed, n_errors, total_checks, i;

    ucie_top #(.FRAME_CYC(40), .SLACK_CYC(4)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sof_token(lvl[3]),
        .bus_reset_seen(lvl[2]), .resume_seen(lvl[1]), .suspend_seen(lvl[0]),
        .in_ep_event(in_ep_event), .usb_irq(usb_irq), .irq(irq));
    ucie_host_model host (.pclk(pclk), .presetn(presetn), .kick(kick),
        .ep_kick(ep_kick), .line_lvl(lvl), .in_ep_event(in_ep_event));

    always #4 pclk = ~pclk;

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd      = prdata;
        serr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic event_in(input logic [3:0] k, input logic [3:0] e);
        kick    <= k;
        ep_kick <= e;
        @(posedge pclk);
        kick    <= 4'h0;
        ep_kick <= 4'h0;
        // Eight more edges let outputs settle before the caller samples them
        repeat (8) @(posedge pclk);
    endtask

    task automatic finish_test;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        finish_test();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {pclk, presetn, psel, penable, pwrite} = 5'h0;
        {paddr, pwdata, kick, ep_kick} = 72'h0;
        seed = 38423;
        n_errors = 0;
        total_checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 32'h18, 32'h0); check(rd, 32'h0);
        apb(1'b0, 32'h1C, 32'h0); check(rd, 32'hF);
        apb(1'b1, 32'h1C, 32'hFFFF_FFF0);
        apb(1'b0, 32'h1C, 32'h0); check(rd, 32'h0);
        apb(1'b0, 32'h30, 32'h0); check({rd[30:0], serr}, 32'h1);
        event_in(4'h8, 4'h0);
        apb(1'b0, 32'h18, 32'h0); check(rd, 32'h8);
        apb(1'b0, 32'h18, 32'h0); check(rd, 32'h0);
        // A real token has locked frame timing: timer running, not suspended
        apb(1'b0, 32'h4C, 32'h0); check(rd, 32'h2);
        // No token now: the frame timer must still produce the event
        repeat (46) @(posedge pclk);
        apb(1'b0, 32'h18, 32'h0); check(rd & 32'h8, 32'h8);
        apb(1'b0, 32'h44, 32'h0);
        event_in(4'h4, 4'h0); check(irq, 1'b1);
        apb(1'b1, 32'h48, 32'h0); check(irq, 1'b0);
        apb(1'b1, 32'h48, 32'h3);
        apb(1'b0, 32'h44, 32'h0); check(irq, 1'b0);
        apb(1'b0, 32'h18, 32'h0); check(rd & 32'h4, 32'h4);
        event_in(4'h2, 4'h0);
        apb(1'b0, 32'h18, 32'h0); check(rd & 32'h2, 32'h0);
        event_in(4'h1, 4'h0);
        apb(1'b0, 32'h18, 32'h0); check(rd & 32'h1, 32'h0);
        apb(1'b1, 32'h40, 32'h1);
        event_in(4'h1, 4'h0);
        apb(1'b0, 32'h18, 32'h0); check(rd & 32'h3, 32'h1);
        // Bus reset stopped the timer; the flagged suspend entered suspend state
        apb(1'b0, 32'h4C, 32'h0); check(rd, 32'h1);
        event_in(4'h2, 4'h0);
        apb(1'b0, 32'h18, 32'h0); check(rd & 32'h3, 32'h2);
        apb(1'b0, 32'h4C, 32'h0); check(rd, 32'h0);
        apb(1'b0, 32'h44, 32'h0);
        // Single-bit corners first, then random enable and event mixes
        for (i = 0; i < 20; i++) begin
            en = (i < 4) ? 4'(1 << i) : 4'($random(seed));
            ev = (i < 4) ? 4'(1 << i) : 4'($random(seed));
            apb(1'b1, 32'h1C, {28'h0, en});
            event_in(4'h0, ev);
            check(usb_irq, |(en & ev));
            check(irq, |(en & ev));
            apb(1'b0, 32'h08, 32'h0); check(rd, {28'h0, ev});
            repeat (2) @(posedge pclk);
            check(usb_irq, 1'b0);
            apb(1'b0, 32'h44, 32'h0); check(rd & 32'h1, {31'h0, |(en & ev)});
        end
        finish_test();
    end
endmodule
